// ===== vfrc_defines.vh
/*
 * Constants for the output-voltage fault response block: command codes,
 * field positions, reset values and the retry delay.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VFRC_DEFINES_VH
`define VFRC_DEFINES_VH

`define VFRC_CMD_OV_LIMIT       8'h40
`define VFRC_CMD_OV_REACT       8'h41
`define VFRC_CMD_UV_LIMIT       8'h44
`define VFRC_CMD_UV_REACT       8'h45
`define VFRC_CMD_CLEAR_FAULTS   8'h03

`define VFRC_REACT_RESET        8'h80
`define VFRC_LIMIT_RESET        16'h0000
`define VFRC_MODE_HI            7
`define VFRC_MODE_LO            6
`define VFRC_RETRY_HI           5
`define VFRC_RETRY_LO           3
`define VFRC_MODE_RETRY         2'h2
`define VFRC_RETRY_NONE         3'h0
`define VFRC_RETRY_FOREVER      3'h7
`define VFRC_UNUSED_BITS        3'h7

`define VFRC_RETRY_DELAY_MS     70
`define VFRC_CLK_MHZ            200
`define VFRC_RETRY_CYCLES       (`VFRC_RETRY_DELAY_MS * 1000 * `VFRC_CLK_MHZ)

`define VFRC_ST_RUN             2'h0
`define VFRC_ST_WAIT            2'h1
`define VFRC_ST_LATCHED         2'h2

`endif

// ===== vfrc_sync2.v
/*
 * Two-flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes the inputs change slowly relative to ref_clk.
 */
`timescale 1ns/100ps
module vfrc_sync2 #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// ===== vfrc_vout_fault.v
/*
 * Output-voltage fault detection and response: OV/UV thresholds and
 * response settings written by command code, sticky status bits,
 * active-low alert, latch-off or endless retry with a fixed delay.
 * Assumes a decoded command port (code, write strobe, data) from a
 * PMBus front end on ref_clk, and measurement words on ref_clk with a
 * valid strobe. Enable and power-good pins are asynchronous.
 */
// Operation
// - Both response settings are 8-bit read/write and reset to 80h.
// - Mode bits 7:6 = 10 select disable-and-retry; 00, 01, 11 are unused.
// - A fault pulls the alert line low and sets a sticky status bit.
// - Retry code 000 after OV keeps the output off until restart.
// - Retry code 000 after UV keeps the output off until faults clear or restart.
// - Retry code 111 restarts endlessly until off, bias loss or fault.
// - Retry delay is fixed at 70 ms; bits 2:0 read back as 111.
// - UV detection is masked in ramp, before power-good and when off.
// - UV threshold is 16-bit unsigned, default 0.85 of strapped setpoint.
// - OV threshold uses the same unsigned encoding; above it is a fault.
`timescale 1ns/100ps
`include "vfrc_defines.vh"
module vfrc_vout_fault #(
  parameter        VW           = 16,
  parameter [31:0] RETRY_CYCLES = `VFRC_RETRY_CYCLES
) (
  input  wire          ref_clk,
  input  wire          reset,
  input  wire [7:0]    cmd_code,
  input  wire          cmd_wr,
  input  wire [VW-1:0] cmd_wdata,
  output reg  [VW-1:0] cmd_rdata,
  input  wire [VW-1:0] vout_strap,
  input  wire [VW-1:0] vout_meas,
  input  wire          vout_meas_valid,
  input  wire          enable_pin,
  input  wire          op_on,
  input  wire          power_good,
  input  wire          ramping,
  input  wire          bias_ok,
  input  wire          other_fault,
  output reg           output_enable,
  output reg           alert_line_n,
  output reg           ov_fault_flag,
  output reg           uv_fault_flag
);
  localparam [31:0] RETRY_LOAD = RETRY_CYCLES - 32'h1;

  wire [2:0] pins_s;
  wire       en_s   = pins_s[0];
  wire       pg_s   = pins_s[1];
  wire       bias_s = pins_s[2];

  vfrc_sync2 #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({bias_ok, power_good, enable_pin}),
    .sync_out (pins_s)
  );

  reg  [VW-1:0] ov_limit_r;
  reg  [VW-1:0] uv_limit_r;
  reg  [7:0]    ov_react_r;
  reg  [7:0]    uv_react_r;
  reg  [1:0]    state_r;
  reg  [31:0]   wait_r;
  reg           ov_cause_r;
  reg           strap_done_r;
  reg           en_q_r;

  // 0.85 ~ 1/2+1/4+1/16+1/32+1/128 (0.8516); 1.15 ~ 1+1/8+1/64+1/128
  wire [VW+1:0] uv_dflt = {2'h0, vout_strap >> 1}
                        + {2'h0, vout_strap >> 2}
                        + {2'h0, vout_strap >> 4}
                        + {2'h0, vout_strap >> 5}
                        + {2'h0, vout_strap >> 7};
  wire [VW+1:0] ov_dflt = {2'h0, vout_strap}
                        + {2'h0, vout_strap >> 3}
                        + {2'h0, vout_strap >> 6}
                        + {2'h0, vout_strap >> 7};

  wire clr_faults = cmd_wr && (cmd_code == `VFRC_CMD_CLEAR_FAULTS);
  wire on_cmd     = en_s && op_on;
  wire enabled    = on_cmd && bias_s;
  wire running    = (state_r == `VFRC_ST_RUN) && enabled;

  wire ov_hit = vout_meas_valid && (vout_meas > ov_limit_r);
  wire uv_hit = vout_meas_valid && (vout_meas < uv_limit_r)
                && running && pg_s && !ramping;
  wire ov_ev  = ov_hit && running;
  wire uv_ev  = uv_hit && !ov_ev;

  // Response of the fault taken now; OV wins a tie
  wire [7:0] react       = ov_ev ? ov_react_r : uv_react_r;
  wire [1:0] react_mode  = react[`VFRC_MODE_HI:`VFRC_MODE_LO];
  wire [2:0] react_try   = react[`VFRC_RETRY_HI:`VFRC_RETRY_LO];
  // Unused mode and retry codes fall back to latch-off
  wire       mode_retry  = (react_mode == `VFRC_MODE_RETRY);
  wire       try_endless = (react_try == `VFRC_RETRY_FOREVER);
  wire       do_retry    = mode_retry && try_endless;

  // Next values, one per register except strap_done_r and en_q_r
  reg  [VW-1:0] ov_limit_nxt;
  reg  [VW-1:0] uv_limit_nxt;
  reg  [7:0]    ov_react_nxt;
  reg  [7:0]    uv_react_nxt;
  reg  [VW-1:0] rdata_nxt;
  reg           ov_flag_nxt;
  reg           uv_flag_nxt;
  reg           alert_nxt;
  reg  [1:0]    state_nxt;
  reg  [31:0]   wait_nxt;
  reg           cause_nxt;
  reg           oe_nxt;

  // Command decode, one wire per writable register
  wire wr_ov_lim = cmd_wr && (cmd_code == `VFRC_CMD_OV_LIMIT);
  wire wr_uv_lim = cmd_wr && (cmd_code == `VFRC_CMD_UV_LIMIT);
  wire wr_ov_rsp = cmd_wr && (cmd_code == `VFRC_CMD_OV_REACT);
  wire wr_uv_rsp = cmd_wr && (cmd_code == `VFRC_CMD_UV_REACT);
  wire restart   = on_cmd && !en_q_r;

  // Strap is taken one cycle after reset release, never under reset
  always @*
  begin
    ov_limit_nxt = ov_limit_r;
    uv_limit_nxt = uv_limit_r;
    ov_react_nxt = ov_react_r;
    uv_react_nxt = uv_react_r;
    if (!strap_done_r)
    begin
      uv_limit_nxt = uv_dflt[VW-1:0];
      ov_limit_nxt = ov_dflt[VW-1:0];
    end
    else
    begin
      if (wr_ov_lim)
        ov_limit_nxt = cmd_wdata;
      if (wr_uv_lim)
        uv_limit_nxt = cmd_wdata;
      if (wr_ov_rsp)
        ov_react_nxt = cmd_wdata[7:0];
      if (wr_uv_rsp)
        uv_react_nxt = cmd_wdata[7:0];
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      strap_done_r <= 1'b0;
      ov_limit_r   <= `VFRC_LIMIT_RESET;
      uv_limit_r   <= `VFRC_LIMIT_RESET;
      ov_react_r   <= `VFRC_REACT_RESET;
      uv_react_r   <= `VFRC_REACT_RESET;
    end
    else
    begin
      strap_done_r <= 1'b1;
      ov_limit_r   <= ov_limit_nxt;
      uv_limit_r   <= uv_limit_nxt;
      ov_react_r   <= ov_react_nxt;
      uv_react_r   <= uv_react_nxt;
    end
  end

  // Readback of the code on the port; unmapped codes show the status
  always @*
  begin
    case (cmd_code)
      `VFRC_CMD_OV_LIMIT:
        rdata_nxt = ov_limit_r;
      `VFRC_CMD_UV_LIMIT:
        rdata_nxt = uv_limit_r;
      `VFRC_CMD_OV_REACT:
        rdata_nxt = {{(VW-8){1'b0}}, ov_react_r[7:3],
                     `VFRC_UNUSED_BITS};
      `VFRC_CMD_UV_REACT:
        rdata_nxt = {{(VW-8){1'b0}}, uv_react_r[7:3],
                     `VFRC_UNUSED_BITS};
      default:
        rdata_nxt = {{(VW-2){1'b0}}, uv_fault_flag, ov_fault_flag};
    endcase
  end

  // Registered so the data port is a flop
  always @(posedge ref_clk)
  begin
    if (reset)
      cmd_rdata <= {VW{1'b0}};
    else
      cmd_rdata <= rdata_nxt;
  end

  // Sticky flags: a new fault wins over a clear in the same cycle
  always @*
  begin
    ov_flag_nxt = ov_ev || (ov_fault_flag && !clr_faults);
    uv_flag_nxt = uv_ev || (uv_fault_flag && !clr_faults);
    alert_nxt   = !(ov_flag_nxt || uv_flag_nxt);
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      ov_fault_flag <= 1'b0;
      uv_fault_flag <= 1'b0;
      alert_line_n  <= 1'b1;
    end
    else
    begin
      ov_fault_flag <= ov_flag_nxt;
      uv_fault_flag <= uv_flag_nxt;
      alert_line_n  <= alert_nxt;
    end
  end

  // Response sequencer
  always @*
  begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    cause_nxt = ov_cause_r;
    oe_nxt    = 1'b0;
    case (state_r)
      `VFRC_ST_RUN:
      begin
        if (ov_ev || uv_ev)
        begin
          cause_nxt = ov_ev;
          if (do_retry)
          begin
            state_nxt = `VFRC_ST_WAIT;
            // Loaded one short: the exit cycle counts toward the delay
            wait_nxt  = RETRY_LOAD;
          end
          else
            state_nxt = `VFRC_ST_LATCHED;
        end
        else
          oe_nxt = enabled;
      end
      `VFRC_ST_WAIT:
      begin
        // Off, bias loss or another shutdown stops the retry loop
        if (!enabled || other_fault)
          state_nxt = `VFRC_ST_LATCHED;
        else if (wait_r == 32'h0)
          state_nxt = `VFRC_ST_RUN;
        else
          wait_nxt = wait_r - 32'h1;
      end
      `VFRC_ST_LATCHED:
      begin
        // OV needs an off-to-on restart; UV a fault clear or a restart
        if (ov_cause_r)
        begin
          if (restart)
            state_nxt = `VFRC_ST_RUN;
        end
        else if (clr_faults || restart)
          state_nxt = `VFRC_ST_RUN;
      end
      default:
        state_nxt = `VFRC_ST_RUN;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r    <= `VFRC_ST_RUN;
      ov_cause_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      ov_cause_r <= cause_nxt;
    end
  end

  // Retry delay counter, loaded on a retrying fault, counts down only while waiting
  always @(posedge ref_clk)
  begin
    if (reset)
      wait_r <= 32'h0;
    else
      wait_r <= wait_nxt;
  end

  // Previous on-command level, for the off-to-on restart edge
  always @(posedge ref_clk)
  begin
    if (reset)
      en_q_r <= 1'b0;
    else
      en_q_r <= on_cmd;
  end

  // Output stays off in every state but RUN
  always @(posedge ref_clk)
  begin
    if (reset)
      output_enable <= 1'b0;
    else
      output_enable <= oe_nxt;
  end
endmodule

// ===== vfrc_chk.sv
/* Checker for the output-voltage fault block.
   Assumes it is bound to vfrc_vout_fault; synchronous reset. */
`timescale 1ns/100ps
module vfrc_chk #(
  parameter VW = 16
) (
  input wire          ref_clk,
  input wire          reset,
  input wire [7:0]    cmd_code,
  input wire          cmd_wr,
  input wire [VW-1:0] cmd_wdata,
  input wire [VW-1:0] cmd_rdata,
  input wire          vout_meas_valid,
  input wire          ramping,
  input wire          output_enable,
  input wire          alert_line_n,
  input wire          ov_fault_flag,
  input wire          uv_fault_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_alert_level: assert property (
    alert_line_n == !(ov_fault_flag || uv_fault_flag)) else $error("alert");
  a_ov_sticky: assert property (
    $fell(ov_fault_flag) |-> $past(cmd_wr && cmd_code == 8'h03))
    else $error("ov flag dropped");
  a_clear_drops: assert property (
    cmd_wr && cmd_code == 8'h03 && !vout_meas_valid |=> !ov_fault_flag
    && !uv_fault_flag) else $error("clear ignored");
  a_trip_off: assert property (
    $rose(ov_fault_flag || uv_fault_flag) |-> $past(vout_meas_valid &&
    output_enable) ##0 !output_enable [*8]) else $error("trip off");
  a_uv_masked: assert property (
    $rose(uv_fault_flag) |-> $past(!ramping)) else $error("uv in ramp");
  a_resp_rw: assert property (
    cmd_wr && cmd_code == 8'h41 ##1 cmd_code == 8'h41 |=>
    cmd_rdata[7:3] == $past(cmd_wdata[7:3], 2)) else $error("resp rw");
  a_low_ones: assert property (
    $past(!reset && (cmd_code == 8'h41 || cmd_code == 8'h45)) |->
    cmd_rdata[2:0] == 3'h7) else $error("low bits");
  a_uv_lim_rw: assert property (
    cmd_wr && cmd_code == 8'h44 ##1 cmd_code == 8'h44 |=>
    cmd_rdata == $past(cmd_wdata, 2)) else $error("uv limit rw");
endmodule
bind vfrc_vout_fault vfrc_chk #(.VW(VW)) vfrc_chk_inst (
  .ref_clk(ref_clk), .reset(reset), .cmd_code(cmd_code),
  .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .vout_meas_valid(vout_meas_valid), .ramping(ramping),
  .output_enable(output_enable), .alert_line_n(alert_line_n),
  .ov_fault_flag(ov_fault_flag), .uv_fault_flag(uv_fault_flag));

// ===== vfrc_host.sv
/* Host and measurement-path model: command writes, reads, strobes.
   Assumes ref_clk; seen carries {output_enable, alert, readback}. */
`timescale 1ns/100ps
module vfrc_host (
  input  wire         ref_clk,
  input  wire  [17:0] seen,
  output logic [7:0]  cmd_code,
  output logic        cmd_wr,
  output logic [15:0] cmd_wdata,
  output logic [15:0] vout_meas,
  output logic        vout_meas_valid
);
  logic [17:0] got;
  event        got_ev;
  initial {cmd_code, cmd_wr, cmd_wdata, vout_meas, vout_meas_valid} = '0;
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_code  <= c;
    cmd_wr    <= 1'b1;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_wr    <= 1'b0;
    cmd_wdata <= ~d;
  endtask
  // Readback lags the code by one register stage
  task automatic rd(input logic [7:0] c);
    @(posedge ref_clk);
    cmd_code <= c;
    repeat (2) @(posedge ref_clk);
    got = seen;
    -> got_ev;
  endtask
  // Stale word inverted so a late sample never matches by luck
  task automatic meas(input logic [15:0] v);
    @(posedge ref_clk);
    vout_meas       <= v;
    vout_meas_valid <= 1'b1;
    @(posedge ref_clk);
    vout_meas_valid <= 1'b0;
    vout_meas       <= ~v;
  endtask
endmodule

// ===== vout_fault_response_ctrl_bench.sv
/* Self-checking bench for the output-voltage fault block.
   Assumes vfrc_host drives the command and measurement ports. */
`timescale 1ns/100ps
module vout_fault_response_ctrl_bench;
  localparam int RC = 20;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        en = 1'b1, op = 1'b1, pg = 1'b1, ramp = 1'b0;
  logic        oe, alert_n;
  logic        bias = 1'b1, ofault = 1'b0;
  logic [15:0] strap = 16'h2000;
  wire         ovf, uvf;
  logic [1:0]  qf[$];
  logic [15:0] rdata, d;
  wire  [7:0]  code;
  wire         wr, mv;
  wire  [15:0] wdata, meas;
  logic [17:0] q[$];
  int          n_fail = 0, comparisons = 0;
  vfrc_host host_inst (.ref_clk(ref_clk), .seen({oe, alert_n, rdata}),
    .cmd_code(code), .cmd_wr(wr), .cmd_wdata(wdata), .vout_meas(meas),
    .vout_meas_valid(mv));
  vfrc_vout_fault #(.RETRY_CYCLES(RC)) vfrc_vout_fault_inst (
    .ref_clk(ref_clk), .reset(reset), .cmd_code(code), .cmd_wr(wr),
    .cmd_wdata(wdata), .cmd_rdata(rdata), .vout_strap(strap),
    .vout_meas(meas), .vout_meas_valid(mv), .enable_pin(en), .op_on(op),
    .power_good(pg), .ramping(ramp), .bias_ok(bias),
    .other_fault(ofault), .output_enable(oe), .alert_line_n(alert_n),
    .ov_fault_flag(ovf), .uv_fault_flag(uvf));
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [17:0] e, input logic [17:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value oe_alert_rdata exp %h seen %h", e, s);
    end
  endtask
  task automatic chk_flags(input logic [1:0] e, input logic [1:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value uv_ov_flags exp %h seen %h", e, s);
    end
  endtask
  always @(host_inst.got_ev)
  begin
    chk(q.pop_front(), host_inst.got);
    if (code == 8'h00)
      chk_flags(qf.pop_front(), {uvf, ovf});
  end
  task automatic ex(input logic [7:0] c, input logic [17:0] e);
    q.push_back(e);
    if (c == 8'h00)
      qf.push_back(e[1:0]);
    host_inst.rd(c);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #20us;
    n_fail++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(32'h2E912FF3));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ex(8'h41, 18'h30087);
    ex(8'h45, 18'h30087);
    for (int i = 0; i < 4; i++)
    begin
      host_inst.wr(8'h45, {8'h00, i[1:0], 6'h38});
      ex(8'h45, {2'b11, 8'h00, i[1:0], 6'h3F});
    end
    d = $urandom;
    host_inst.wr(8'h44, d);
    ex(8'h44, {2'b11, d});
    host_inst.wr(8'h44, 16'h1000);
    host_inst.wr(8'h40, 16'h2400);
    $display("test registers done");
    host_inst.meas(16'h2400);
    ex(8'h00, 18'h30000);
    host_inst.meas(16'h2401);
    ex(8'h00, 18'h00001);
    host_inst.wr(8'h03, 16'h0000);
    ex(8'h00, 18'h10000);
    en <= 1'b0;
    repeat (8) @(posedge ref_clk);
    en <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ex(8'h00, 18'h30000);
    $display("test ov latch done");
    ramp <= 1'b1;
    host_inst.meas(16'h0FFF);
    ex(8'h00, 18'h30000);
    ramp <= 1'b0;
    pg <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host_inst.meas(16'h0FFF);
    ex(8'h00, 18'h30000);
    pg <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_inst.meas(16'h0FFF);
    ex(8'h00, 18'h00002);
    host_inst.wr(8'h03, 16'h0000);
    repeat (4) @(posedge ref_clk);
    ex(8'h00, 18'h30000);
    $display("test uv done");
    d = $urandom;
    host_inst.wr(8'h41, {8'h00, 5'h17, d[2:0]});
    ex(8'h41, 18'h300BF);
    host_inst.meas(16'hFFFF);
    repeat (RC - 4) @(posedge ref_clk);
    ex(8'h00, 18'h00001);
    repeat (4) @(posedge ref_clk);
    ex(8'h00, 18'h20001);
    host_inst.meas(16'hFFFF);
    ofault <= 1'b1;
    @(posedge ref_clk);
    ofault <= 1'b0;
    repeat (RC + 8) @(posedge ref_clk);
    ex(8'h00, 18'h00001);
    op <= 1'b0;
    repeat (4) @(posedge ref_clk);
    op <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ex(8'h00, 18'h20001);
    host_inst.meas(16'hFFFF);
    bias <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bias <= 1'b1;
    repeat (RC + 8) @(posedge ref_clk);
    ex(8'h00, 18'h00001);
    $display("test retry done");
    end_of_test;
  end
endmodule
